// ---- tdc_cfg.svh ----
// tdc_cfg.svh: addresses, bit positions and reset values of the dual timer/counter
// assumes it is included by the package and the timer modules only
`ifndef TDC_CFG_SVH
`define TDC_CFG_SVH

`define TDC_ADDR_CTRL 8'h88
`define TDC_ADDR_MODE 8'h89
`define TDC_ADDR_ZERO_LOW 8'h8A
`define TDC_ADDR_FIRST_LOW 8'h8B
`define TDC_ADDR_ZERO_HIGH 8'h8C
`define TDC_ADDR_FIRST_HIGH 8'h8D

`define TDC_CTRL_FIRST_OVF 7
`define TDC_CTRL_FIRST_RUN 6
`define TDC_CTRL_ZERO_OVF 5
`define TDC_CTRL_ZERO_RUN 4

`define TDC_MODE_FIRST_GATE 7
`define TDC_MODE_FIRST_SRC 6
`define TDC_MODE_FIRST_SEL_HI 5
`define TDC_MODE_FIRST_SEL_LO 4
`define TDC_MODE_ZERO_GATE 3
`define TDC_MODE_ZERO_SRC 2
`define TDC_MODE_ZERO_SEL_HI 1
`define TDC_MODE_ZERO_SEL_LO 0

`define TDC_RESET_BYTE 8'h00
`define TDC_PRESCALE_MAX 5'h1F
`define TDC_BYTE_MAX 8'hFF

`endif

// ---- tdc_pkg.sv ----
// tdc_pkg: types shared by the dual timer/counter modules
// assumes tdc_cfg.svh sits in the include path
package tdc_pkg;
  `include "tdc_cfg.svh"

  typedef enum logic [1:0] {
    TDC_MODE_PRESCALED = 2'b00,
    TDC_MODE_SIXTEEN = 2'b01,
    TDC_MODE_RELOAD = 2'b10,
    TDC_MODE_SPLIT = 2'b11
  } tdc_mode_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tdc_sfr_req_t;

  typedef struct packed {
    logic ovf;
    logic [7:0] th;
    logic [7:0] tl;
  } tdc_cnt_t;
endpackage

// ---- tdc_pin_sync.sv ----
// tdc_pin_sync: two-flop synchroniser plus falling-edge detector for one pin
// assumes the pin is asynchronous to clk and held at least one cycle per level
`timescale 1ns/100ps
module tdc_pin_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level,
  output logic fall
);
  import tdc_pkg::*;

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  // high sample followed by low sample, one clock period apart
  assign fall = prev_reg & ~sync_reg;

  sequence s_high_then_low;
    pin ##1 !pin;
  endsequence

  a_edge_two_cycles: assert property (@(posedge clk) disable iff (!rst_n)
    fall |-> !$past(pin, 2) && $past(pin, 3))
    else $error("edge pulse without a high-low sample pair");
  a_edge_seen: assert property (@(posedge clk) disable iff (!rst_n)
    s_high_then_low |-> ##2 fall)
    else $error("sampled falling edge not detected");
endmodule

// ---- tdc_timer_pair.sv ----
// tdc_timer_pair: two 16-bit timer/counters behind the core's special function registers
// assumes sfr_req comes from core logic on clk; pins are asynchronous and synchronised here
`timescale 1ns/100ps
`include "tdc_cfg.svh"
module tdc_timer_pair (
  input wire logic clk,
  input wire logic rst_n,
  input wire tdc_pkg::tdc_sfr_req_t sfr_req,
  input wire logic vector_ack_zero,
  input wire logic vector_ack_first,
  input wire logic count_pin_zero,
  input wire logic count_pin_first,
  input wire logic gate_pin_zero,
  input wire logic gate_pin_first,
  output logic [7:0] sfr_rdata,
  output logic zero_overflow_flag,
  output logic first_overflow_flag
);
  import tdc_pkg::*;

  function automatic tdc_cnt_t tdc_step(input tdc_mode_t mode, input logic [7:0] th, input logic [7:0] tl,
                                        input logic tick);
    logic [5:0] ps;
    logic [16:0] wide;
    tdc_step = '0;
    ps = {1'b0, tl[4:0]} + {5'h00, tick};
    wide = {1'b0, th, tl} + {16'h0000, tick};
    case (mode)
      TDC_MODE_PRESCALED: begin
        // upper three low-byte bits are left untouched
        tdc_step.tl = {tl[7:5], ps[4:0]};
        tdc_step.th = th + {7'h00, ps[5]};
        tdc_step.ovf = ps[5] & (th == `TDC_BYTE_MAX);
      end
      TDC_MODE_SIXTEEN: begin
        tdc_step = wide;
      end
      TDC_MODE_RELOAD: begin
        tdc_step.ovf = tick & (tl == `TDC_BYTE_MAX);
        tdc_step.th = th;
        tdc_step.tl = tdc_step.ovf ? th : tl + {7'h00, tick};
      end
      default: begin
        tdc_step.ovf = tick & (tl == `TDC_BYTE_MAX);
        tdc_step.th = th;
        tdc_step.tl = tl + {7'h00, tick};
      end
    endcase
  endfunction

  function automatic logic tdc_hit(input tdc_sfr_req_t req, input logic [7:0] addr);
    tdc_hit = req.wr & (req.addr == addr);
  endfunction

  logic [7:0] mode_reg;
  logic zero_run_bit_reg;
  logic first_run_bit_reg;
  logic zero_ovf_reg;
  logic first_ovf_reg;
  logic [7:0] zero_high_reg;
  logic [7:0] zero_low_reg;
  logic [7:0] first_high_reg;
  logic [7:0] first_low_reg;
  logic [7:0] rdata_reg;

  logic [3:0] pin_raw;
  logic [3:0] pin_level;
  logic [3:0] pin_fall;
  assign pin_raw = {count_pin_first, count_pin_zero, gate_pin_first, gate_pin_zero};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      tdc_pin_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin(pin_raw[gi]),
        .level(pin_level[gi]),
        .fall(pin_fall[gi])
      );
    end
  endgenerate

  wire tdc_mode_t zero_mode = tdc_mode_t'(mode_reg[`TDC_MODE_ZERO_SEL_HI:`TDC_MODE_ZERO_SEL_LO]);
  wire tdc_mode_t first_mode = tdc_mode_t'(mode_reg[`TDC_MODE_FIRST_SEL_HI:`TDC_MODE_FIRST_SEL_LO]);
  wire zero_split = (zero_mode == TDC_MODE_SPLIT);

  // gate pin only matters while the gate bit is set
  wire zero_run = zero_run_bit_reg & (~mode_reg[`TDC_MODE_ZERO_GATE] | pin_level[0]);
  wire first_run = first_run_bit_reg & (~mode_reg[`TDC_MODE_FIRST_GATE] | pin_level[1]);
  // clock count or pin edge per source bit
  wire zero_src = mode_reg[`TDC_MODE_ZERO_SRC] ? pin_fall[2] : 1'b1;
  wire first_src = mode_reg[`TDC_MODE_FIRST_SRC] ? pin_fall[3] : 1'b1;
  wire zero_tick = zero_run & zero_src;
  wire first_tick = first_run & first_src & (first_mode != TDC_MODE_SPLIT);

  wire tdc_cnt_t zero_st = tdc_step(zero_mode, zero_high_reg, zero_low_reg, zero_tick);
  wire tdc_cnt_t first_st = tdc_step(first_mode, first_high_reg, first_low_reg, first_tick);

  // split high byte counts clocks only, under the first run bit, no gating
  wire [7:0] zero_high_split = zero_high_reg + {7'h00, first_run_bit_reg};
  wire split_ovf = zero_split & first_run_bit_reg & (zero_high_reg == `TDC_BYTE_MAX);

  wire wr_ctrl = tdc_hit(sfr_req, `TDC_ADDR_CTRL);
  wire wr_mode = tdc_hit(sfr_req, `TDC_ADDR_MODE);
  wire wr_zl = tdc_hit(sfr_req, `TDC_ADDR_ZERO_LOW);
  wire wr_fl = tdc_hit(sfr_req, `TDC_ADDR_FIRST_LOW);
  wire wr_zh = tdc_hit(sfr_req, `TDC_ADDR_ZERO_HIGH);
  wire wr_fh = tdc_hit(sfr_req, `TDC_ADDR_FIRST_HIGH);

  // in split mode the high byte of timer zero owns the first flag
  wire zero_set = zero_st.ovf;
  wire first_set = zero_split ? split_ovf : first_st.ovf;

  // hardware set beats both the vector acknowledge and a software write
  wire zero_ovf_next = zero_set | (wr_ctrl ? sfr_req.wdata[`TDC_CTRL_ZERO_OVF] : (zero_ovf_reg & ~vector_ack_zero));
  wire first_ovf_next = first_set |
                        (wr_ctrl ? sfr_req.wdata[`TDC_CTRL_FIRST_OVF] : (first_ovf_reg & ~vector_ack_first));

  // software write to a count byte wins over the count in that cycle
  wire [7:0] zero_low_next = wr_zl ? sfr_req.wdata : zero_st.tl;
  wire [7:0] zero_high_next = wr_zh ? sfr_req.wdata : (zero_split ? zero_high_split : zero_st.th);
  wire [7:0] first_low_next = wr_fl ? sfr_req.wdata : first_st.tl;
  wire [7:0] first_high_next = wr_fh ? sfr_req.wdata : first_st.th;

  // external interrupt bits of the control byte live elsewhere and read zero
  wire [7:0] ctrl_view = {first_ovf_reg, first_run_bit_reg, zero_ovf_reg, zero_run_bit_reg, 4'h0};
  wire [7:0] rdata_next = (sfr_req.addr == `TDC_ADDR_CTRL) ? ctrl_view :
                          (sfr_req.addr == `TDC_ADDR_MODE) ? mode_reg :
                          (sfr_req.addr == `TDC_ADDR_ZERO_LOW) ? zero_low_reg :
                          (sfr_req.addr == `TDC_ADDR_FIRST_LOW) ? first_low_reg :
                          (sfr_req.addr == `TDC_ADDR_ZERO_HIGH) ? zero_high_reg :
                          (sfr_req.addr == `TDC_ADDR_FIRST_HIGH) ? first_high_reg : `TDC_RESET_BYTE;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= `TDC_RESET_BYTE;
      zero_run_bit_reg <= 1'b0;
      first_run_bit_reg <= 1'b0;
      zero_ovf_reg <= 1'b0;
      first_ovf_reg <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode_reg <= sfr_req.wdata;
      end
      if (wr_ctrl) begin
        zero_run_bit_reg <= sfr_req.wdata[`TDC_CTRL_ZERO_RUN];
        first_run_bit_reg <= sfr_req.wdata[`TDC_CTRL_FIRST_RUN];
      end
      zero_ovf_reg <= zero_ovf_next;
      first_ovf_reg <= first_ovf_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_low_reg <= `TDC_RESET_BYTE;
      zero_high_reg <= `TDC_RESET_BYTE;
      first_low_reg <= `TDC_RESET_BYTE;
      first_high_reg <= `TDC_RESET_BYTE;
    end else begin
      zero_low_reg <= zero_low_next;
      zero_high_reg <= zero_high_next;
      first_low_reg <= first_low_next;
      first_high_reg <= first_high_next;
    end
  end

  // read data is held until the next read strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= `TDC_RESET_BYTE;
    end else if (sfr_req.rd) begin
      rdata_reg <= rdata_next;
    end
  end

  assign sfr_rdata = rdata_reg;
  assign zero_overflow_flag = zero_ovf_reg;
  assign first_overflow_flag = first_ovf_reg;

  wire no_zero_wr = ~wr_zl & ~wr_zh & ~wr_ctrl & ~wr_mode;
  wire no_first_wr = ~wr_fl & ~wr_fh & ~wr_ctrl & ~wr_mode;

  sequence s_zero_low_wraps;
    (zero_mode == TDC_MODE_RELOAD) && zero_tick && (zero_low_reg == 8'hFF) && no_zero_wr;
  endsequence

  // carry checks: the low byte must land on zero as the high byte steps
  sequence s_zero_wide_wrap;
    (zero_mode == TDC_MODE_SIXTEEN) && zero_tick && (zero_low_reg == `TDC_BYTE_MAX) && no_zero_wr;
  endsequence

  sequence s_zero_byte_carried;
    (zero_low_reg == `TDC_RESET_BYTE) && (zero_high_reg == $past(zero_high_reg) + 8'h01);
  endsequence

  a_timer_clock_count: assert property (@(posedge clk) disable iff (!rst_n)
    (zero_mode == TDC_MODE_SIXTEEN && !mode_reg[2] && !mode_reg[3] && zero_run_bit_reg && no_zero_wr &&
     zero_low_reg != 8'hFF) |=> zero_low_reg == $past(zero_low_reg) + 8'h01)
    else $error("timer zero low byte missed a clock count");
  a_counter_edge: assert property (@(posedge clk) disable iff (!rst_n)
    (first_mode == TDC_MODE_SIXTEEN && mode_reg[6] && first_run && no_first_wr && !pin_fall[3]) |=>
    $stable(first_low_reg))
    else $error("counter moved without a pin edge");
  a_gate_first: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_reg[7] && !pin_level[1] && first_mode != TDC_MODE_SPLIT && no_first_wr) |=>
    $stable(first_low_reg) && $stable(first_high_reg))
    else $error("first timer counted while gated off");
  a_gate_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_reg[3] && !pin_level[0] && no_zero_wr && !zero_split) |=>
    $stable(zero_low_reg) && $stable(zero_high_reg))
    else $error("zero timer counted while gated off");
  // pin source must count a detected edge, not the clock
  a_source_pin: assert property (@(posedge clk) disable iff (!rst_n)
    (zero_mode == TDC_MODE_SIXTEEN && mode_reg[`TDC_MODE_ZERO_SRC] && zero_run && pin_fall[2] && no_zero_wr &&
     zero_low_reg != `TDC_BYTE_MAX) |=> zero_low_reg == $past(zero_low_reg) + 8'h01)
    else $error("pin source edge was not counted");
  a_prescale_carry: assert property (@(posedge clk) disable iff (!rst_n)
    (zero_mode == TDC_MODE_PRESCALED && zero_tick && zero_low_reg[4:0] == 5'h1F && no_zero_wr) |=>
    zero_high_reg == $past(zero_high_reg) + 8'h01 && zero_low_reg[4:0] == 5'h00)
    else $error("prescaler wrap did not carry into high byte");
  a_reload_value: assert property (@(posedge clk) disable iff (!rst_n)
    s_zero_low_wraps |=> zero_low_reg == $past(zero_high_reg) && zero_ovf_reg)
    else $error("reload mode did not restore the low byte");
  a_first_stopped: assert property (@(posedge clk) disable iff (!rst_n)
    (first_mode == TDC_MODE_SPLIT && no_first_wr) |=> $stable(first_low_reg) && $stable(first_high_reg))
    else $error("first timer counted in stopped mode");
  a_split_high: assert property (@(posedge clk) disable iff (!rst_n)
    (zero_split && first_run_bit_reg && !wr_zh) |=> zero_high_reg == $past(zero_high_reg) + 8'h01)
    else $error("split high byte did not follow first run bit");
  a_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (vector_ack_first && !first_set && !wr_ctrl) |=> !first_ovf_reg)
    else $error("vector acknowledge left the flag set");
  a_run_stopped: assert property (@(posedge clk) disable iff (!rst_n)
    (!zero_run_bit_reg && no_zero_wr && !zero_split) ##1 (!zero_run_bit_reg && no_zero_wr) |->
    $stable(zero_low_reg) && $stable(zero_high_reg))
    else $error("zero timer counted with run bit clear");

  // counting paths not covered above
  a_wide_carry: assert property (@(posedge clk) disable iff (!rst_n)
    s_zero_wide_wrap |=> s_zero_byte_carried)
    else $error("sixteen-bit count did not carry into high byte");
  a_reload_step: assert property (@(posedge clk) disable iff (!rst_n)
    (zero_mode == TDC_MODE_RELOAD && zero_tick && zero_low_reg != `TDC_BYTE_MAX && no_zero_wr) |=>
    zero_low_reg == $past(zero_low_reg) + 8'h01 && $stable(zero_high_reg))
    else $error("reload mode step was wrong");
  // prescaler must not touch the high byte or the upper low bits before it wraps
  a_prescale_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (zero_mode == TDC_MODE_PRESCALED && zero_tick && zero_low_reg[4:0] != `TDC_PRESCALE_MAX && no_zero_wr) |=>
    $stable(zero_high_reg) && zero_low_reg[7:5] == $past(zero_low_reg[7:5]))
    else $error("prescaler disturbed bytes before wrapping");
  a_first_clock: assert property (@(posedge clk) disable iff (!rst_n)
    (first_mode == TDC_MODE_PRESCALED && !mode_reg[`TDC_MODE_FIRST_SRC] && !mode_reg[`TDC_MODE_FIRST_GATE] &&
     first_run_bit_reg && no_first_wr && first_low_reg[4:0] != `TDC_PRESCALE_MAX) |=>
    first_low_reg[4:0] == $past(first_low_reg[4:0]) + 5'h01)
    else $error("first timer prescaler missed a clock count");
  // an open gate must let the count through, not only a closed one stop it
  a_gate_zero_open: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_reg[`TDC_MODE_ZERO_GATE] && pin_level[0] && zero_run_bit_reg && zero_mode == TDC_MODE_SIXTEEN &&
     !mode_reg[`TDC_MODE_ZERO_SRC] && no_zero_wr && zero_low_reg != `TDC_BYTE_MAX) |=>
    zero_low_reg == $past(zero_low_reg) + 8'h01)
    else $error("zero timer held while gate pin high");
  a_gate_first_open: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_reg[`TDC_MODE_FIRST_GATE] && pin_level[1] && first_run_bit_reg && first_mode == TDC_MODE_SIXTEEN &&
     !mode_reg[`TDC_MODE_FIRST_SRC] && no_first_wr && first_low_reg != `TDC_BYTE_MAX) |=>
    first_low_reg == $past(first_low_reg) + 8'h01)
    else $error("first timer held while gate pin high");
  a_split_low: assert property (@(posedge clk) disable iff (!rst_n)
    (zero_split && zero_tick && zero_low_reg != `TDC_BYTE_MAX && no_zero_wr) |=>
    zero_low_reg == $past(zero_low_reg) + 8'h01)
    else $error("split low byte missed a count");
  a_split_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (zero_split && !first_run_bit_reg && !wr_zh) |=> $stable(zero_high_reg))
    else $error("split high byte counted without first run bit");
  // flag set, hold and clear, then run-bit load and stop; a set in the clear cycle wins, so only quiet cycles are checked for clears
  a_first_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    (first_mode == TDC_MODE_PRESCALED && !zero_split && first_tick && first_low_reg[4:0] == `TDC_PRESCALE_MAX &&
     first_high_reg == `TDC_BYTE_MAX) |=> first_ovf_reg)
    else $error("first timer overflow left the flag clear");
  a_zero_ack: assert property (@(posedge clk) disable iff (!rst_n)
    (vector_ack_zero && !zero_set && !wr_ctrl) |=> !zero_ovf_reg)
    else $error("vector acknowledge left the zero flag set");
  a_flag_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (zero_ovf_reg && !vector_ack_zero && !wr_ctrl) |=> zero_ovf_reg)
    else $error("zero flag dropped without a clear");
  a_run_load: assert property (@(posedge clk) disable iff (!rst_n)
    wr_ctrl |=> zero_run_bit_reg == $past(sfr_req.wdata[`TDC_CTRL_ZERO_RUN]) &&
    first_run_bit_reg == $past(sfr_req.wdata[`TDC_CTRL_FIRST_RUN]))
    else $error("run bits did not follow the control write");
  a_run_first_stopped: assert property (@(posedge clk) disable iff (!rst_n)
    (!first_run_bit_reg && no_first_wr) |=> $stable(first_low_reg) && $stable(first_high_reg))
    else $error("first timer counted with run bit clear");
endmodule

// ---- tdc_pin_model.sv ----
// tdc_pin_model: external event source on one count pin
// assumes start is raised by the bench off the falling edge; pin idles high like a pulled-up port pin
`timescale 1ns/100ps
module tdc_pin_model #(
  parameter int N_FALL = 4
) (
  input wire logic clk,
  input wire logic start,
  output logic pin,
  output logic busy
);
  initial begin
    pin = 1'b1;
    busy = 1'b0;
  end
  // one clock per level: fastest legal source, exactly half the clock rate
  always @(posedge start) begin
    busy = 1'b1;
    repeat (N_FALL) begin
      @(negedge clk) pin = 1'b0;
      @(negedge clk) pin = 1'b1;
    end
    @(negedge clk) busy = 1'b0;
  end
endmodule

// ---- tdc_timer_pair_tb.sv ----
// tdc_timer_pair_tb: self-checking bench for the dual timer/counter
// assumes tdc_pkg, tdc_timer_pair and tdc_pin_model are compiled before it
`timescale 1ns/100ps
module tdc_timer_pair_tb;
  import tdc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  tdc_sfr_req_t req = '0;
  logic ack_z = 1'b0;
  logic ack_f = 1'b0;
  logic gate_z = 1'b0;
  logic gate_f = 1'b0;
  logic [1:0] go = 2'b00;
  wire [1:0] cnt_pin;
  wire [1:0] busy;
  logic [7:0] rdata;
  logic ovf_z;
  logic ovf_f;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;

  always #2.5 clk = ~clk;

  // one event source per count pin, index 0 for timer zero
  tdc_pin_model tdc_pin_model_inst [1:0] (.clk(clk), .start(go), .pin(cnt_pin), .busy(busy));

  tdc_timer_pair tdc_timer_pair_inst (
    .clk(clk), .rst_n(rst_n), .sfr_req(req), .vector_ack_zero(ack_z), .vector_ack_first(ack_f),
    .count_pin_zero(cnt_pin[0]), .count_pin_first(cnt_pin[1]), .gate_pin_zero(gate_z), .gate_pin_first(gate_f),
    .sfr_rdata(rdata), .zero_overflow_flag(ovf_z), .first_overflow_flag(ovf_f)
  );

  task automatic report_and_stop();
    if (n_fail == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) req = {1'b1, 1'b0, a, d};
    @(negedge clk) req = '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk) req = {1'b0, 1'b1, a, 8'h00};
    @(negedge clk) req = '0;
    chk(rdata, exp);
  endtask

  // run for exactly n counting edges, n >= 2, then stop
  task automatic cnt(input logic [7:0] ctrl, input int n);
    wr(8'h88, ctrl);
    repeat (n - 2) @(negedge clk);
    wr(8'h88, 8'h00);
  endtask

  task automatic ack(input bit f);
    @(negedge clk) if (f) ack_f = 1'b1; else ack_z = 1'b1;
    @(negedge clk) {ack_f, ack_z} = 2'b00;
    @(negedge clk);
  endtask

  task automatic t_reset();
    for (int a = 8'h88; a < 8'h8E; a++) rd(a[7:0], 8'h00);
    rd(8'h8F, 8'h00);
  endtask

  task automatic t_timer16();
    wr(8'h89, 8'h01);
    wr(8'h8A, 8'hFE);
    wr(8'h8C, 8'h00);
    cnt(8'h10, 5);
    repeat (4) @(negedge clk);
    rd(8'h8A, 8'h03);
    rd(8'h8C, 8'h01);
  endtask

  // overflow lands on the stop edge, where a set beats the software write
  task automatic t_prescale();
    wr(8'h89, 8'h00);
    wr(8'h8B, 8'hFD);
    wr(8'h8D, 8'hFF);
    wr(8'h8A, 8'h1F);
    wr(8'h8C, 8'h00);
    cnt(8'h50, 3);
    rd(8'h8B, 8'hE0);
    rd(8'h8D, 8'h00);
    rd(8'h8A, 8'h02);
    rd(8'h8C, 8'h01);
    chk({7'h00, ovf_f}, 8'h01);
    ack(1'b1);
    chk({7'h00, ovf_f}, 8'h00);
  endtask

  task automatic t_reload();
    wr(8'h89, 8'h02);
    wr(8'h8C, 8'hFE);
    wr(8'h8A, 8'hFF);
    cnt(8'h10, 3);
    rd(8'h8A, 8'hFE);
    rd(8'h8C, 8'hFE);
    rd(8'h88, 8'h20);
    ack(1'b0);
    chk({7'h00, ovf_z}, 8'h00);
  endtask

  task automatic t_counter(input bit f);
    logic [7:0] lo;
    lo = f ? 8'h8B : 8'h8A;
    wr(8'h89, f ? 8'h50 : 8'h05);
    wr(lo, 8'h00);
    wr(lo + 8'h02, 8'h00);
    wr(8'h88, f ? 8'h40 : 8'h10);
    repeat (6) @(negedge clk);
    go[f] = 1'b1;
    @(negedge clk) go[f] = 1'b0;
    for (int i = 0; i < 40 && busy[f] === 1'b1; i++) @(negedge clk);
    repeat (6) @(negedge clk);
    wr(8'h88, 8'h00);
    rd(lo, 8'h04);
  endtask

  task automatic t_gate(input bit f);
    logic [7:0] lo;
    lo = f ? 8'h8B : 8'h8A;
    wr(8'h89, f ? 8'h90 : 8'h09);
    wr(lo, 8'h00);
    cnt(f ? 8'h40 : 8'h10, 6);
    rd(lo, 8'h00);
    if (f) gate_f = 1'b1; else gate_z = 1'b1;
    repeat (4) @(negedge clk);
    cnt(f ? 8'h40 : 8'h10, 5);
    rd(lo, 8'h05);
    {gate_f, gate_z} = 2'b00;
  endtask

  task automatic t_split();
    wr(8'h89, 8'h33);
    wr(8'h8A, 8'h00);
    wr(8'h8C, 8'h00);
    wr(8'h8B, 8'h00);
    cnt(8'h40, 4);
    rd(8'h8C, 8'h04);
    rd(8'h8A, 8'h00);
    rd(8'h8B, 8'h00);
    cnt(8'h10, 3);
    rd(8'h8A, 8'h03);
    rd(8'h8C, 8'h04);
  endtask

  // reset in mid-run must clear counts, flags, run and mode bits alike
  task automatic t_midreset();
    wr(8'h89, 8'h33);
    wr(8'h88, 8'hF0);
    repeat (3) @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk(rdata, 8'h00);
    chk({6'h00, ovf_f, ovf_z}, 8'h00);
    rst_n = 1'b1;
    t_reset();
  endtask

  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_timer16();
    t_prescale();
    t_reload();
    t_counter(1'b0);
    t_counter(1'b1);
    t_gate(1'b0);
    t_gate(1'b1);
    t_split();
    t_midreset();
    report_and_stop();
  end
endmodule
